// ==== sptx_consts.vh ====
// Constants for the serial audio input stage
`ifndef SPTX_CONSTS_VH
`define SPTX_CONSTS_VH
`define SPTX_FMT_LJ       2'h0
`define SPTX_FMT_I2S      2'h1
`define SPTX_FMT_RJ       2'h2
`define SPTX_WID_16       2'h0
`define SPTX_WID_18       2'h1
`define SPTX_WID_20       2'h2
`define SPTX_WID_24       2'h3
`define SPTX_RJ_DLY_16    6'h10
`define SPTX_RJ_DLY_18    6'h0E
`define SPTX_RJ_DLY_20    6'h0C
`define SPTX_RJ_DLY_24    6'h08
`define SPTX_BITS_16      6'h10
`define SPTX_BITS_18      6'h12
`define SPTX_BITS_20      6'h14
`define SPTX_BITS_24      6'h18
`define SPTX_LJ_DLY       6'h00
`define SPTX_I2S_DLY      6'h01
`define SPTX_SLOT_START   6'h01
`define SPTX_CNT_MAX      6'h3F
`endif

// ==== sptx_serial_in.v ====
// Serial audio input stage: deserialises left/right words from an external source
// Notes on behaviour
// - Words are accepted in left-justified, I2S or right-justified framing, chosen by fmtSel.
// - Word width is 16, 18, 20 or 24 bits, chosen by widthSel, and the source sends that width.
// - Frame sync high marks the left word and low the right word, and each word is tagged by that level.
// - Data and frame sync are sampled on rising serial clock edges, where the source keeps them valid.
// - In right-justified framing the MSB comes 16, 14, 12 or 8 serial clocks after the sync change.
`timescale 1ns/10ps
`include "sptx_consts.vh"
module sptx_serial_in (
    clk,
    arst_n,
    serClk,
    frameSync,
    serData,
    fmtSel,
    widthSel,
    wordData,
    wordLeft,
    wordValid
);
    input  wire        clk;
    input  wire        arst_n;
    input  wire        serClk;
    input  wire        frameSync;
    input  wire        serData;
    input  wire [1:0]  fmtSel;
    input  wire [1:0]  widthSel;
    output reg  [23:0] wordData;
    output reg         wordLeft;
    output reg         wordValid;

    function [5:0] bitsOf;
        input [1:0] w;
        begin
            case (w)
                `SPTX_WID_16: bitsOf = `SPTX_BITS_16;
                `SPTX_WID_18: bitsOf = `SPTX_BITS_18;
                `SPTX_WID_20: bitsOf = `SPTX_BITS_20;
                default:      bitsOf = `SPTX_BITS_24;
            endcase
        end
    endfunction

    function [5:0] rjDelay;
        input [1:0] w;
        begin
            case (w)
                `SPTX_WID_16: rjDelay = `SPTX_RJ_DLY_16;
                `SPTX_WID_18: rjDelay = `SPTX_RJ_DLY_18;
                `SPTX_WID_20: rjDelay = `SPTX_RJ_DLY_20;
                default:      rjDelay = `SPTX_RJ_DLY_24;
            endcase
        end
    endfunction

    // Where the MSB sits, counted in serial clock rises from the sync change rise (0)
    function [5:0] firstPosOf;
        input [1:0] f;
        input [1:0] w;
        begin
            case (f)
                `SPTX_FMT_I2S: firstPosOf = `SPTX_I2S_DLY;
                `SPTX_FMT_RJ:  firstPosOf = rjDelay(w);
                default:       firstPosOf = `SPTX_LJ_DLY;
            endcase
        end
    endfunction

    // Slot states; WAIT keeps a partial slot after reset from being handed on
    localparam [1:0]   ST_WAIT  = 2'h0;
    localparam [1:0]   ST_LEAD  = 2'h1;
    localparam [1:0]   ST_SHIFT = 2'h2;
    localparam [1:0]   ST_DONE  = 2'h3;
    localparam integer NPIN     = 3;

    reg        clkPrev;
    reg        fsPrev;
    reg [1:0]  state;
    reg [5:0]  slotCnt;
    reg [5:0]  bitCnt;
    reg [23:0] shiftReg;
    reg        slotLeft;

    reg        next_fsPrev;
    reg [1:0]  next_state;
    reg [5:0]  next_slotCnt;
    reg [5:0]  next_bitCnt;
    reg [23:0] next_shiftReg;
    reg        next_slotLeft;
    reg [23:0] next_wordData;
    reg        next_wordLeft;
    reg        next_wordValid;

    // Two-flop synchronisers, one per pin; logic reads only the second stage
    wire [2:0] pinRaw = {serData, frameSync, serClk};
    wire [2:0] pinSync;
    genvar     i;

    generate
        for (i = 0; i < NPIN; i = i + 1) begin : g_sync
            reg [1:0] stage;
            always @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    stage <= 2'h0;
                end else begin
                    stage <= {stage[0], pinRaw[i]};
                end
            end
            assign pinSync[i] = stage[1];
        end
    endgenerate

    wire        clkSyncd = pinSync[0];
    wire        fsSyncd  = pinSync[1];
    wire        datSyncd = pinSync[2];

    // A rise is seen about two clocks late; data and sync come from the same sample as the clock
    wire        riseEdge = clkSyncd & ~clkPrev;
    wire        fsChange = riseEdge & (fsSyncd != fsPrev);
    wire [5:0]  nBits    = bitsOf(widthSel);
    wire [5:0]  firstPos = firstPosOf(fmtSel, widthSel);
    // Saturating so an over-long slot cannot wrap and open a second word
    wire [5:0]  slotStep = (slotCnt != `SPTX_CNT_MAX) ? slotCnt + 6'h01 : slotCnt;
    wire [5:0]  bitStep  = bitCnt + 6'h01;
    wire [23:0] shifted  = {shiftReg[22:0], datSyncd};

    // Slot tracking and word capture
    always @* begin
        next_fsPrev    = fsPrev;
        next_state     = state;
        next_slotCnt   = slotCnt;
        next_bitCnt    = bitCnt;
        next_shiftReg  = shiftReg;
        next_slotLeft  = slotLeft;
        next_wordData  = wordData;
        next_wordLeft  = wordLeft;
        next_wordValid = 1'b0;
        if (riseEdge) begin
            next_fsPrev = fsSyncd;
        end
        if (fsChange) begin
            // The slot that just ended is handed on unless still in WAIT; a new slot opens on this rise
            if (state != ST_WAIT) begin
                next_wordData  = shiftReg;
                next_wordLeft  = slotLeft;
                next_wordValid = 1'b1;
            end
            next_slotLeft = fsSyncd;
            next_slotCnt  = `SPTX_SLOT_START;
            if (firstPos == `SPTX_LJ_DLY) begin
                // Left-justified: MSB sits on the rise that carries the sync change
                next_shiftReg = {23'h000000, datSyncd};
                next_bitCnt   = 6'h01;
                next_state    = ST_SHIFT;
            end else begin
                next_shiftReg = 24'h000000;
                next_bitCnt   = 6'h00;
                next_state    = ST_LEAD;
            end
        end else if (riseEdge) begin
            case (state)
                ST_WAIT: begin
                    next_state = ST_WAIT;
                end
                ST_LEAD: begin
                    next_slotCnt = slotStep;
                    if (slotCnt >= firstPos) begin
                        next_shiftReg = shifted;
                        next_bitCnt   = bitStep;
                        next_state    = ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    next_slotCnt  = slotStep;
                    next_shiftReg = shifted;
                    next_bitCnt   = bitStep;
                    if (bitStep >= nBits) begin
                        // Bits past the selected width are left on the line
                        next_state = ST_DONE;
                    end
                end
                ST_DONE: begin
                    // Word complete; only the slot position moves on
                    next_slotCnt = slotStep;
                end
                default: begin
                    next_state = ST_WAIT;
                end
            endcase
        end
    end

    // Outputs are registered; word and tag hold until the next slot ends
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            clkPrev   <= 1'b0;
            fsPrev    <= 1'b0;
            state     <= ST_WAIT;
            slotCnt   <= 6'h00;
            bitCnt    <= 6'h00;
            shiftReg  <= 24'h000000;
            slotLeft  <= 1'b0;
            wordData  <= 24'h000000;
            wordLeft  <= 1'b0;
            wordValid <= 1'b0;
        end else begin
            clkPrev   <= clkSyncd;
            fsPrev    <= next_fsPrev;
            state     <= next_state;
            slotCnt   <= next_slotCnt;
            bitCnt    <= next_bitCnt;
            shiftReg  <= next_shiftReg;
            slotLeft  <= next_slotLeft;
            wordData  <= next_wordData;
            wordLeft  <= next_wordLeft;
            wordValid <= next_wordValid;
        end
    end
endmodule

// ==== sptx_serial_in_chk.sv ====
// Port checker for the serial audio input stage
`timescale 1ns/10ps
module sptx_serial_in_chk (
    input wire        clk,
    input wire        arst_n,
    input wire        frameSync,
    input wire [1:0]  widthSel,
    input wire [23:0] wordData,
    input wire        wordLeft,
    input wire        wordValid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    pulse_one_a: assert property (wordValid |=> !wordValid) else $error("word strobe too long");
    hold_word_a: assert property (
        !wordValid |-> $stable(wordData) && $stable(wordLeft)) else $error("word moved");
    tag_level_a: assert property (wordValid |-> wordLeft != frameSync) else $error("bad channel tag");
    sync_cause_a: assert property (
        wordValid |-> $past(frameSync, 20) != frameSync) else $error("no sync change");
    width_zero_a: assert property (
        wordValid |-> (wordData >> (widthSel == 2'h3 ? 24 : 16 + 2 * widthSel)) == 24'h0)
        else $error("bits beyond width");
    valid_space_a: assert property (
        wordValid |=> (!wordValid) [*5]) else $error("words too close");
endmodule

// ==== sptx_src.sv ====
// Behavioural serial audio source sending one framed pair of words
`timescale 1ns/10ps
module sptx_src (
    output reg serClk,
    output reg frameSync,
    output reg serData
);
    initial {serClk, frameSync, serData} = 3'h0;
    // Lead rise low, 32 rises left, 32 right, one closing rise; clock stops after
    task frame(input [1:0] fm, input integer n, input [23:0] lw, input [23:0] rw);
        integer s, k;
        begin
            for (s = 0; s < 66; s = s + 1) begin
                frameSync = (s >= 1 && s <= 32) || s == 65;
                k = (s - 1) % 32 - (fm == 2'h1 ? 1 : fm == 2'h2 ? 32 - n : 0);
                serData = (s >= 1 && s <= 64 && k >= 0 && k < n) ?
                          (s <= 32 ? lw[n-1-k] : rw[n-1-k]) : ~serData;
                #24 serClk = 1'b1;
                #24 serClk = 1'b0;
            end
        end
    endtask
endmodule

// ==== sptx_serial_in_tb.sv ====
// Testbench for the serial audio input stage
`timescale 1ns/10ps
`include "sptx_consts.vh"
module sptx_serial_in_tb;
    reg         clk = 0;
    reg         arst_n = 0;
    reg  [1:0]  fmtSel = 0;
    reg  [1:0]  widthSel = 0;
    wire        serClk, frameSync, serData, wordLeft, wordValid;
    wire [23:0] wordData;
    integer     err_total = 0, cmp_count = 0, n, got, t;
    always #2.5 clk = ~clk;
    sptx_serial_in i_sptx_serial_in (.clk(clk), .arst_n(arst_n), .serClk(serClk), .frameSync(frameSync),
        .serData(serData), .fmtSel(fmtSel), .widthSel(widthSel), .wordData(wordData), .wordLeft(wordLeft),
        .wordValid(wordValid));
    sptx_src i_sptx_src (.serClk(serClk), .frameSync(frameSync), .serData(serData));
    task compare_word(input [24:0] exp, input [24:0] act);
        begin
            cmp_count = cmp_count + 1;
            if (exp !== act) begin
                err_total = err_total + 1;
                $display("unexpected at %0t: exp %h got %h", $time, exp, act);
            end
        end
    endtask
    task compare_count(input [7:0] exp, input [7:0] act);
        begin
            cmp_count = cmp_count + 1;
            if (exp !== act) begin
                err_total = err_total + 1;
                $display("unexpected word count at %0t: exp %h got %h", $time, exp, act);
            end
        end
    endtask
    // Reset per case so the lead rise is always the dropped partial slot
    task run_case(input [1:0] fm, input [1:0] ws);
        reg [23:0] lw, rw;
        begin
            @(negedge clk) {arst_n, fmtSel, widthSel} = {1'b0, fm, ws};
            repeat (3) @(negedge clk);
            arst_n = 1'b1;
            n = (ws == `SPTX_WID_24) ? 24 : 16 + 2 * ws;
            lw = 24'hC5A3E9 >> (24 - n);
            rw = 24'hB3F1D7 >> (24 - n);
            got = 0;
            fork
                i_sptx_src.frame(fm, n, lw, rw);
                for (t = 0; t < 4000; t = t + 1) begin
                    @(negedge clk);
                    if (wordValid === 1'b1) begin
                        compare_word({got == 0, got == 0 ? lw : rw}, {wordLeft, wordData});
                        got = got + 1;
                    end
                end
            join
            compare_count(8'h02, got[7:0]);
        end
    endtask
    // Left-justified: MSB on the rise that carries the sync change, toggling filler after the word
    task scen_left_just;
        integer ws;
        begin
            for (ws = 0; ws < 4; ws = ws + 1) begin
                run_case(`SPTX_FMT_LJ, ws[1:0]);
            end
        end
    endtask
    // I2S: MSB one rise after the sync change
    task scen_i2s;
        integer ws;
        begin
            for (ws = 0; ws < 4; ws = ws + 1) begin
                run_case(`SPTX_FMT_I2S, ws[1:0]);
            end
        end
    endtask
    // Right-justified: 64 rises per frame, LSB on the rise before the next sync change
    task scen_right_just;
        integer ws;
        begin
            for (ws = 0; ws < 4; ws = ws + 1) begin
                run_case(`SPTX_FMT_RJ, ws[1:0]);
            end
        end
    endtask
    // Unused framing code falls back to left-justified
    task scen_fmt_three;
        integer ws;
        begin
            for (ws = 0; ws < 4; ws = ws + 1) begin
                run_case(2'h3, ws[1:0]);
            end
        end
    endtask
    task summarize;
        begin
            $display("mismatches %0d compares %0d", err_total, cmp_count);
            if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask
    initial begin
        scen_left_just;
        scen_i2s;
        scen_right_just;
        scen_fmt_three;
        summarize;
    end
endmodule
bind sptx_serial_in sptx_serial_in_chk i_sptx_serial_in_chk (.clk(clk), .arst_n(arst_n), .frameSync(frameSync),
    .widthSel(widthSel), .wordData(wordData), .wordLeft(wordLeft), .wordValid(wordValid));
